// ===== rtl/fseq_defs.svh
// Register offsets, field positions, reset values and timing counts of the fast step sequencer.
// Assumes inclusion by bare name from the sequencer module and the bench.
`ifndef FSEQ_DEFS_SVH
`define FSEQ_DEFS_SVH
`define OFS_CTRL        8'h00
`define OFS_LOOPS       8'h04
`define OFS_FINAL       8'h08
`define OFS_PERIOD      8'h0C
`define OFS_HOLD_LEVEL  8'h10
`define OFS_STEP_COUNT  8'h14
`define OFS_STEP_SEL    8'h18
`define OFS_STEP_DATA   8'h1C
`define OFS_EDIT_CMD    8'h20
`define OFS_FILL_A      8'h24
`define OFS_FILL_B      8'h28
`define OFS_FILL_IDX    8'h2C
`define OFS_FILL_CMD    8'h30
`define OFS_STATUS      8'h34
`define OFS_POSITION    8'h38
`define CTRL_ENABLE     0
`define CTRL_LOAD_ON    1
`define CTRL_MODE       2
`define CTRL_RANGE_LO   4
`define CTRL_INFINITE   8
`define CTRL_HOLD_EN    9
`define EDIT_INSERT     0
`define EDIT_DELETE     1
`define DATA_TRIG       31
`define FILL_END_LO     16
`define MAX_STEPS       1000
`define MIN_STEPS       3
`define MAX_LOOPS       9999
`define RST_LOOPS       14'h0001
`define RST_FINAL       10'h3E8
`define RST_PERIOD      15'h0001
`define MAX_PERIOD      15'h5DC0
`define CLK_PERIOD_NS   100
`define PERIOD_UNIT_NS  25000
`define UNIT_CYCLES     (`PERIOD_UNIT_NS / `CLK_PERIOD_NS)
`endif

// ===== rtl/fseq_pkg.sv
// Types shared by the fast step sequencer and its bench.
// Assumes fseq_defs.svh on the include path.
package fseq_pkg;
    typedef enum logic { constant_current_mode, constant_resistance_mode } mode_t;
    typedef enum logic [2:0] {
        range_lowi_lowv, range_midi_lowv, range_highi_lowv,
        range_lowi_highv, range_midi_highv, range_highi_highv
    } range_t;
    typedef enum logic [1:0] { st_idle, st_run, st_done } seq_state_t;
    typedef struct packed {
        logic        load_active;
        mode_t       mode;
        range_t      range;
        logic [23:0] level;
    } setpoint_t;
endpackage

// ===== rtl/fast_step_sequencer.sv
// Fast step sequencer: an APB register file, a step table of up to 1000 levels and the player.
// Assumes an APB master on pclk and a load regulator that follows the setpoint outputs.
`timescale 1ns/1ps
`default_nettype none
`include "fseq_defs.svh"

module fast_step_sequencer
    import fseq_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = `UNIT_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  setpoint_t   setpoint,
    output var  logic        step_trigger_output
);
    logic        enable_reg, load_on_reg, infinite_reg, hold_en_reg;
    mode_t       mode_reg;
    range_t      range_reg;
    logic [13:0] loops_reg;
    logic [9:0]  final_reg;
    logic [14:0] period_reg;
    logic [23:0] hold_level_reg;
    logic [10:0] count_reg;
    logic [9:0]  sel_reg;
    logic [23:0] fill_a_reg, fill_b_reg;
    logic [9:0]  fill_s_reg, fill_e_reg, fill_idx_reg;
    logic        fill_armed_reg, fill_busy_reg;
    seq_state_t  state_reg;
    logic [9:0]  step_reg;
    logic [13:0] loop_reg;
    logic [15:0] unit_cnt_reg;
    logic [14:0] units_reg;
    logic [23:0] level_mem [0:`MAX_STEPS-1];
    logic        trig_mem  [0:`MAX_STEPS-1];

    // A write takes effect only at the edge where pready is seen high; read data is latched one edge earlier.
    logic        access, wr, rd_phase;
    logic [31:0] rd_val;
    logic        unmapped;
    logic        do_insert, do_delete, do_fill, sel_valid;
    logic [9:0]  final_eff;
    logic        step_end, last_loop;
    assign access    = psel && penable;
    assign wr        = access && pready && pwrite;
    assign rd_phase  = access && !pready;
    assign do_insert = wr && paddr == `OFS_EDIT_CMD && pwdata[`EDIT_INSERT] && count_reg < 11'(`MAX_STEPS);
    assign do_delete = wr && paddr == `OFS_EDIT_CMD && pwdata[`EDIT_DELETE] && count_reg > 11'(`MIN_STEPS);
    assign do_fill   = wr && paddr == `OFS_FILL_CMD && pwdata[0];
    assign sel_valid = sel_reg != 10'h000 && {1'b0, sel_reg} <= count_reg;
    assign final_eff = ({1'b0, final_reg} > count_reg) ? count_reg[9:0] : final_reg;
    assign last_loop = !infinite_reg && loop_reg >= loops_reg;

    function automatic logic [9:0] clamp_index(input logic [9:0] v);
        if (v == 10'h000)
            return 10'h001;
        if (v > 10'(`MAX_STEPS))
            return 10'(`MAX_STEPS);
        return v;
    endfunction

    // Linear level for index i between (s, a) and (e, b); a divider is traded for single-cycle fills.
    function automatic logic [23:0] interp(input logic [9:0] i);
        logic signed [25:0] d;
        logic signed [11:0] n, w;
        logic signed [37:0] p, r;
        d = $signed({2'b00, fill_b_reg}) - $signed({2'b00, fill_a_reg});
        n = $signed({2'b00, i}) - $signed({2'b00, fill_s_reg});
        w = $signed({2'b00, fill_e_reg}) - $signed({2'b00, fill_s_reg});
        p = d * n;
        r = $signed({14'h0000, fill_a_reg});
        if (w > 12'sh000)
            r = r + p / w;
        return r[23:0];
    endfunction

    function automatic logic in_fill(input logic [9:0] i);
        return i >= fill_s_reg && i <= fill_e_reg;
    endfunction

    always_comb begin
        unmapped = 1'b0;
        case (paddr)
            `OFS_CTRL:       rd_val = {22'h0, hold_en_reg, infinite_reg, 1'b0, range_reg, 1'b0, mode_reg,
                                       load_on_reg, enable_reg};
            `OFS_LOOPS:      rd_val = {18'h0, loops_reg};
            `OFS_FINAL:      rd_val = {22'h0, final_reg};
            `OFS_PERIOD:     rd_val = {17'h0, period_reg};
            `OFS_HOLD_LEVEL: rd_val = {8'h00, hold_level_reg};
            `OFS_STEP_COUNT: rd_val = {21'h0, count_reg};
            `OFS_STEP_SEL:   rd_val = {22'h0, sel_reg};
            `OFS_STEP_DATA:  rd_val = sel_valid ? {trig_mem[sel_reg-10'h001], 7'h00, level_mem[sel_reg-10'h001]}
                                                : 32'h0000_0000;
            `OFS_FILL_A:     rd_val = {8'h00, fill_a_reg};
            `OFS_FILL_B:     rd_val = {8'h00, fill_b_reg};
            `OFS_FILL_IDX:   rd_val = {6'h00, fill_e_reg, 6'h00, fill_s_reg};
            `OFS_STATUS:     rd_val = {28'h0, fill_busy_reg, fill_armed_reg, state_reg == st_done,
                                       state_reg == st_run};
            `OFS_POSITION:   rd_val = {2'b00, loop_reg, 6'h00, step_reg};
            `OFS_EDIT_CMD, `OFS_FILL_CMD: rd_val = 32'h0000_0000;
            default: begin
                rd_val   = 32'h0000_0000;
                unmapped = 1'b1;
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_phase;
            prdata  <= (rd_phase && !pwrite) ? rd_val : 32'h0000_0000;
            pslverr <= rd_phase && unmapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg     <= 1'b0;
            load_on_reg    <= 1'b0;
            mode_reg       <= constant_current_mode;
            range_reg      <= range_lowi_lowv;
            infinite_reg   <= 1'b0;
            hold_en_reg    <= 1'b0;
            loops_reg      <= `RST_LOOPS;
            final_reg      <= `RST_FINAL;
            period_reg     <= `RST_PERIOD;
            hold_level_reg <= 24'h00_0000;
            fill_a_reg     <= 24'h00_0000;
            fill_b_reg     <= 24'h00_0000;
            fill_s_reg     <= 10'h001;
            fill_e_reg     <= 10'h001;
        end else if (wr) begin
            case (paddr)
                `OFS_CTRL: begin
                    enable_reg   <= pwdata[`CTRL_ENABLE];
                    load_on_reg  <= pwdata[`CTRL_LOAD_ON];
                    mode_reg     <= mode_t'(pwdata[`CTRL_MODE]);
                    if (pwdata[`CTRL_RANGE_LO+:3] <= 3'(range_highi_highv))
                        range_reg <= range_t'(pwdata[`CTRL_RANGE_LO+:3]);
                    infinite_reg <= pwdata[`CTRL_INFINITE];
                    hold_en_reg  <= pwdata[`CTRL_HOLD_EN];
                end
                `OFS_LOOPS:
                    if (pwdata[13:0] != 14'h0000 && pwdata[13:0] <= 14'(`MAX_LOOPS))
                        loops_reg <= pwdata[13:0];
                `OFS_FINAL:      final_reg <= clamp_index(pwdata[9:0]);
                `OFS_PERIOD:
                    if (pwdata[14:0] != 15'h0000 && pwdata[14:0] <= `MAX_PERIOD)
                        period_reg <= pwdata[14:0];
                `OFS_HOLD_LEVEL: hold_level_reg <= pwdata[23:0];
                `OFS_FILL_A:     fill_a_reg <= pwdata[23:0];
                `OFS_FILL_B:     fill_b_reg <= pwdata[23:0];
                `OFS_FILL_IDX: begin
                    fill_s_reg <= clamp_index(pwdata[9:0]);
                    fill_e_reg <= clamp_index(pwdata[`FILL_END_LO+:10]);
                end
                default: ;
            endcase
        end
    end

    // Step table bookkeeping: count, selection and the fill walker.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg      <= 11'h000;
            sel_reg        <= 10'h000;
            fill_armed_reg <= 1'b0;
            fill_busy_reg  <= 1'b0;
            fill_idx_reg   <= 10'h001;
        end else begin
            if (do_insert) begin
                count_reg <= count_reg + 11'h001;
                sel_reg   <= 10'(count_reg + 11'h001);
            end else if (do_delete) begin
                count_reg <= count_reg - 11'h001;
                if ({1'b0, sel_reg} >= count_reg)
                    sel_reg <= 10'(count_reg - 11'h001);
            end else if (wr && paddr == `OFS_STEP_SEL && pwdata[9:0] != 10'h000
                         && {1'b0, pwdata[9:0]} <= count_reg) begin
                sel_reg <= pwdata[9:0];
            end
            if (do_fill) begin
                fill_armed_reg <= 1'b1;
                fill_busy_reg  <= 1'b1;
                fill_idx_reg   <= fill_s_reg;
            end else if (fill_busy_reg) begin
                // Steps beyond the current count are left to the insert path.
                if (fill_idx_reg >= fill_e_reg || {1'b0, fill_idx_reg} >= count_reg)
                    fill_busy_reg <= 1'b0;
                fill_idx_reg <= fill_idx_reg + 10'h001;
            end
        end
    end

    // Storage has no reset; only inserted entries are ever read.
    always_ff @(posedge pclk) begin
        if (do_insert) begin
            level_mem[count_reg[9:0]] <= (fill_armed_reg && in_fill(10'(count_reg + 11'h001)))
                                         ? interp(10'(count_reg + 11'h001)) : 24'h00_0000;
            trig_mem[count_reg[9:0]]  <= 1'b0;
        end
        if (wr && paddr == `OFS_STEP_DATA && sel_valid) begin
            level_mem[sel_reg-10'h001] <= pwdata[23:0];
            trig_mem[sel_reg-10'h001]  <= pwdata[`DATA_TRIG];
        end
        if (fill_busy_reg && !do_fill && {1'b0, fill_idx_reg} <= count_reg)
            level_mem[fill_idx_reg-10'h001] <= interp(fill_idx_reg);
    end

    // Period timer: units of 25 us, each UNIT_CYCLES clocks long.
    assign step_end = state_reg == st_run && unit_cnt_reg == 16'(UNIT_CYCLES - 1) && units_reg == period_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_cnt_reg <= 16'h0000;
            units_reg    <= 15'h0001;
        end else if (state_reg != st_run || step_end) begin
            unit_cnt_reg <= 16'h0000;
            units_reg    <= 15'h0001;
        end else if (unit_cnt_reg == 16'(UNIT_CYCLES - 1)) begin
            unit_cnt_reg <= 16'h0000;
            units_reg    <= units_reg + 15'h0001;
        end else begin
            unit_cnt_reg <= unit_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= st_idle;
            step_reg  <= 10'h000;
            loop_reg  <= 14'h0000;
        end else if (!enable_reg || !load_on_reg) begin
            state_reg <= st_idle;
        end else begin
            case (state_reg)
                st_idle:
                    if (count_reg >= 11'(`MIN_STEPS)) begin
                        state_reg <= st_run;
                        step_reg  <= 10'h001;
                        loop_reg  <= 14'h0001;
                    end
                st_run:
                    if (step_end) begin
                        if (step_reg < final_eff) begin
                            step_reg <= step_reg + 10'h001;
                        end else if (last_loop) begin
                            state_reg <= st_done;
                        end else begin
                            step_reg <= 10'h001;
                            if (loop_reg < 14'(`MAX_LOOPS))
                                loop_reg <= loop_reg + 14'h0001;
                        end
                    end
                st_done: ;
                default: state_reg <= st_idle;
            endcase
        end
    end

    // Setpoint follows the step at once: no ramp is ever applied.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setpoint            <= '0;
            step_trigger_output <= 1'b0;
        end else begin
            setpoint.mode  <= mode_reg;
            setpoint.range <= range_reg;
            case (state_reg)
                st_run: begin
                    setpoint.load_active <= 1'b1;
                    setpoint.level       <= level_mem[step_reg-10'h001];
                end
                st_done: begin
                    setpoint.load_active <= hold_en_reg;
                    setpoint.level       <= hold_en_reg ? hold_level_reg : 24'h00_0000;
                end
                default: begin
                    setpoint.load_active <= 1'b0;
                    setpoint.level       <= 24'h00_0000;
                end
            endcase
            step_trigger_output <= state_reg == st_run && unit_cnt_reg == 16'h0000 && units_reg == 15'h0001
                                   && trig_mem[step_reg-10'h001];
        end
    end
endmodule // fast_step_sequencer
`default_nettype wire

// ===== sim/fseq_props.sv
// Checker for the fast step sequencer ports: APB answer timing and the step outputs.
// Assumes it is bound into fast_step_sequencer, one clock and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fseq_props
    import fseq_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = 250
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire setpoint_t   setpoint,
    input wire logic        step_trigger_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("pready missing in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside the answer");
    a_trig_pulse: assert property (step_trigger_output |=> !step_trigger_output)
        else $error("trigger longer than one cycle");
    a_trig_active: assert property (step_trigger_output |-> setpoint.load_active)
        else $error("trigger while load inactive");
    a_range_legal: assert property ($unsigned(setpoint.range) <= 3'h5)
        else $error("range code out of the six pairs");
    a_level_hold: assert property (step_trigger_output |=> $stable(setpoint.level))
        else $error("level moved inside a step");
    c_trigger: cover property (step_trigger_output);
    c_refused: cover property (pready && pslverr);
    c_load_off: cover property ($fell(setpoint.load_active));
endmodule // fseq_props
bind fast_step_sequencer fseq_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .setpoint(setpoint), .step_trigger_output(step_trigger_output));
`default_nettype wire

// ===== sim/load_source_model.sv
// Model of the source under test: logs each level the load applies and the trigger pulses.
// Assumes the bench reads and clears its logs hierarchically.
`timescale 1ns/1ps
`default_nettype none
module load_source_model
    import fseq_pkg::*;
(
    input wire logic      pclk,
    input wire logic      presetn,
    input wire setpoint_t setpoint,
    input wire logic      step_trigger_output
);
    logic [23:0] seen[$];
    int          gaps[$];
    int          trigs = 0;
    int          cnt = 0;
    // A ramp would show as many small changes one cycle apart, so gaps expose it.
    always @(posedge pclk) begin
        cnt++;
        if (presetn && setpoint.load_active && (seen.size() == 0 || setpoint.level !== seen[$])) begin
            seen.push_back(setpoint.level);
            gaps.push_back(cnt);
            cnt = 0;
        end
        if (presetn && step_trigger_output === 1'b1) trigs++;
    end
endmodule // load_source_model
`default_nettype wire

// ===== sim/fast_step_sequencer_test.sv
// Bench for the fast step sequencer: APB register tasks, step table editing, fill and playback.
// Assumes the design and the checker are compiled first; UNIT_CYCLES is cut to 2 for speed.
`timescale 1ns/1ps
`default_nettype none
`include "fseq_defs.svh"
module fast_step_sequencer_test;
    import fseq_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, trig;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic        err_seen;
    setpoint_t   setpoint;
    int          errors = 0, checks = 0, cyc = 0;
    logic [23:0] exp_lv[7] = '{24'h00_1000, 24'h00_1100, 24'h00_1200, 24'h00_1000, 24'h00_1100,
                               24'h00_1200, 24'h00_0077};
    fast_step_sequencer #(.UNIT_CYCLES(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .setpoint(setpoint), .step_trigger_output(trig));
    load_source_model pm (.pclk(pclk), .presetn(presetn), .setpoint(setpoint), .step_trigger_output(trig));
    always #50 pclk = ~pclk;
    task automatic stop_test();
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Entered just after a rising edge; releases the bus and idles one cycle before returning.
    // Only the bench's cycle ceiling ends a wait for pready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_status(input int b, input logic v);
        int k;
        k = 0;
        do begin
            rd(`OFS_STATUS);
            k++;
        end while (r[b] !== v && k < 200);
        chk("status", {31'h0, r[b]}, {31'h0, v});
    endtask
    task automatic step_level(input logic [9:0] i, input logic [23:0] e);
        wr(`OFS_STEP_SEL, {22'h0, i});
        rd(`OFS_STEP_DATA);
        chk("step level", {8'h00, r[23:0]}, {8'h00, e});
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFS_LOOPS); chk("loops reset", r, 32'h0000_0001);
        rd(`OFS_FINAL); chk("final reset", r, 32'h0000_03e8);
        rd(`OFS_PERIOD); chk("period reset", r, 32'h0000_0001);
        rd(8'h3C); chk("unmapped err", {31'h0, err_seen}, 32'h0000_0001);
        chk("unmapped data", r, 32'h0000_0000);
        wr(`OFS_LOOPS, 32'h0000_0000); rd(`OFS_LOOPS); chk("loops zero", r, 32'h0000_0001);
        wr(`OFS_LOOPS, 32'h0000_270f); rd(`OFS_LOOPS); chk("loops max", r, 32'h0000_270f);
        wr(`OFS_PERIOD, 32'h0000_5dc1); rd(`OFS_PERIOD); chk("period over", r, 32'h0000_0001);
        wr(`OFS_PERIOD, 32'h0000_5dc0); rd(`OFS_PERIOD); chk("period max", r, 32'h0000_5dc0);
        wr(`OFS_FILL_A, 32'h0000_0100);
        wr(`OFS_FILL_B, 32'h0000_0400);
        wr(`OFS_FILL_IDX, 32'h0004_0001);
        wr(`OFS_FILL_CMD, 32'h0000_0001);
        for (int i = 1; i <= 4; i++) begin
            wr(`OFS_EDIT_CMD, 32'h0000_0001);
            rd(`OFS_STEP_DATA); chk("prefill", {8'h00, r[23:0]}, i * 32'h0000_0100);
        end
        wr(`OFS_EDIT_CMD, 32'h0000_0002);
        wr(`OFS_EDIT_CMD, 32'h0000_0002);
        rd(`OFS_STEP_COUNT); chk("min steps", r, 32'h0000_0003);
        wr(`OFS_STEP_SEL, 32'h0000_0004); rd(`OFS_STEP_SEL); chk("sel refused", r, 32'h0000_0003);
        wr(`OFS_EDIT_CMD, 32'h0000_0001);
        rd(`OFS_STEP_DATA); chk("reinsert", {8'h00, r[23:0]}, 32'h0000_0400);
        wr(`OFS_FILL_A, 32'h0000_1000);
        wr(`OFS_FILL_B, 32'h0000_1300);
        wr(`OFS_FILL_CMD, 32'h0000_0001);
        wait_status(3, 1'b0);
        step_level(10'h003, 24'h00_1200);
        step_level(10'h004, 24'h00_1300);
        wr(`OFS_STEP_SEL, 32'h0000_0001);
        wr(`OFS_STEP_DATA, 32'h8000_1000);
        wr(`OFS_PERIOD, 32'h0000_0001);
        wr(`OFS_LOOPS, 32'h0000_0002);
        wr(`OFS_FINAL, 32'h0000_0003);
        wr(`OFS_HOLD_LEVEL, 32'h0000_0077);
        pm.seen.delete(); pm.gaps.delete(); pm.trigs = 0;
        wr(`OFS_CTRL, 32'h0000_0257);
        wait_status(1, 1'b1);
        chk("level count", pm.seen.size(), 32'h0000_0007);
        for (int k = 0; k < 7; k++) chk("level", {8'h00, pm.seen[k]}, {8'h00, exp_lv[k]});
        for (int k = 1; k < 6; k++) chk("step gap", pm.gaps[k], 32'h0000_0002);
        chk("triggers", pm.trigs, 32'h0000_0002);
        chk("hold on", {31'h0, setpoint.load_active}, 32'h0000_0001);
        chk("mode", {31'h0, setpoint.mode}, {31'h0, constant_resistance_mode});
        chk("range", {29'h0, setpoint.range}, {29'h0, range_highi_highv});
        rd(`OFS_POSITION);
        chk("position", r, 32'h0002_0003);
        wr(`OFS_CTRL, 32'h0000_0000);
        // The state drop launched at the task's last edge reaches the setpoint one edge later; let two edges pass.
        repeat (2) @(posedge pclk);
        chk("load off", {31'h0, setpoint.load_active}, 32'h0000_0000);
        wr(`OFS_LOOPS, 32'h0000_0001);
        wr(`OFS_CTRL, 32'h0000_0003);
        wait_status(1, 1'b1);
        chk("no hold", {31'h0, setpoint.load_active}, 32'h0000_0000);
        chk("no hold level", {8'h00, setpoint.level}, 32'h0000_0000);
        chk("mode cc", {31'h0, setpoint.mode}, {31'h0, constant_current_mode});
        // With one loop programmed, only the infinite option keeps it running this long.
        wr(`OFS_CTRL, 32'h0000_0000);
        wr(`OFS_CTRL, 32'h0000_0103);
        repeat (60) @(posedge pclk);
        rd(`OFS_STATUS);
        chk("infinite running", {31'h0, r[0]}, 32'h0000_0001);
        rd(`OFS_POSITION);
        chk("infinite loops", {31'h0, r[29:16] > 14'h0002}, 32'h0000_0001);
        wr(`OFS_CTRL, 32'h0000_0000);
        stop_test();
    end
endmodule // fast_step_sequencer_test
`default_nettype wire
